// ==== core/pxb_alloc.sv ====
// Priority allocator placing enabled signals on the next free pins.
`timescale 1ns/1ps
`default_nettype none
module pxb_alloc (
    // Requests
    input  wire logic [pxb_pkg::NUM_SIGS-1:0] sig_en_i,
    input  wire logic [pxb_pkg::NUM_PINS-1:0] pin_skip_i,
    // Pin view
    output logic [pxb_pkg::NUM_PINS-1:0]      pin_used_o,
    output logic [4:0]                        pin_sig_o [pxb_pkg::NUM_PINS],
    // Signal view
    output logic [pxb_pkg::NUM_SIGS-1:0]      sig_placed_o,
    output logic [4:0]                        sig_pin_o [pxb_pkg::NUM_SIGS],
    output logic [5:0]                        placed_count_o
);

    logic [5:0] rank [pxb_pkg::NUM_PINS];
    logic [5:0] slot [pxb_pkg::NUM_SIGS];
    logic [5:0] free_n;
    logic [5:0] en_n;

    // The k-th enabled signal goes to the k-th pin not skipped.
    always_comb begin
        free_n = 6'h00;
        en_n   = 6'h00;
        placed_count_o = 6'h00;
        for (int p = 0; p < pxb_pkg::NUM_PINS; p++) begin
            rank[p] = free_n;
            if (!pin_skip_i[p]) free_n = free_n + 6'h01;
        end
        for (int s = 0; s < pxb_pkg::NUM_SIGS; s++) begin
            slot[s] = en_n;
            if (sig_en_i[s]) en_n = en_n + 6'h01;
            sig_placed_o[s] = 1'b0;
            sig_pin_o[s]    = 5'h00;
        end
        for (int p = 0; p < pxb_pkg::NUM_PINS; p++) begin
            pin_used_o[p] = 1'b0;
            pin_sig_o[p]  = 5'h00;
            for (int s = 0; s < pxb_pkg::NUM_SIGS; s++) begin
                if (sig_en_i[s] && !pin_skip_i[p] && slot[s] == rank[p]) begin
                    pin_used_o[p]   = 1'b1;
                    pin_sig_o[p]    = 5'(s);
                    sig_placed_o[s] = 1'b1;
                    sig_pin_o[s]    = 5'(p);
                    placed_count_o  = placed_count_o + 6'h01;
                end
            end
        end
    end

endmodule
`default_nettype wire

// ==== core/pxb_crossbar.sv ====
// Port I/O crossbar: routing registers, pin allocation and pin drive.
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

module pxb_crossbar (
    // Clock and reset
    input  wire logic                          clk_sys_i,
    input  wire logic                          sys_rst_i,
    // Wishbone slave
    input  wire logic [pxb_pkg::ADR_W-1:0]     wb_adr_i,
    input  wire logic [31:0]                   wb_dat_i,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic                          wb_we_i,
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    output logic      [31:0]                   wb_dat_o,
    output logic                               wb_ack_o,
    // Peripheral side
    input  wire logic [pxb_pkg::NUM_SIGS-1:0]  periph_out_i,
    input  wire logic [pxb_pkg::NUM_SIGS-1:0]  periph_oe_i,
    output logic      [pxb_pkg::NUM_SIGS-1:0]  periph_in_o,
    input  wire logic                          uart_a_mode0_i,
    input  wire logic                          uart_b_mode0_i,
    // Memory interface
    input  wire logic                          memif_nonmux_sel_i,
    input  wire logic [2:0]                    memif_strobe_i,
    // Port configuration
    input  wire logic [pxb_pkg::NUM_PINS-1:0]  latch_i,
    input  wire logic [pxb_pkg::NUM_PINS-1:0]  pushpull_i,
    input  wire logic [7:0]                    analog_skip_i,
    // Pins
    input  wire logic [pxb_pkg::NUM_PINS-1:0]  pin_i,
    output logic      [pxb_pkg::NUM_PINS-1:0]  pin_o,
    output logic      [pxb_pkg::NUM_PINS-1:0]  pin_oe_o,
    output logic      [pxb_pkg::NUM_PINS-1:0]  pullup_en_o,
    output logic      [pxb_pkg::NUM_PINS-1:0]  pin_level_o
);

    // ********************************************************
    // Registers
    // ********************************************************

    pxb_pkg::pxb_ctrl_a_s  ctrl_a;
    pxb_pkg::pxb_ctrl_b_s  ctrl_b;
    pxb_pkg::pxb_ctrl_c_s  ctrl_c;
    pxb_pkg::pxb_status_s  status;
    pxb_pkg::pxb_status_s  next_status;

    // The slave adds one wait state, so every access takes two edges.
    pxb_wb_regs u_regs (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .wb_adr_i  (wb_adr_i),
        .wb_dat_i  (wb_dat_i),
        .wb_sel_i  (wb_sel_i),
        .wb_we_i   (wb_we_i),
        .wb_cyc_i  (wb_cyc_i),
        .wb_stb_i  (wb_stb_i),
        .wb_dat_o  (wb_dat_o),
        .wb_ack_o  (wb_ack_o),
        .status_i  (status),
        .ctrl_a_o  (ctrl_a),
        .ctrl_b_o  (ctrl_b),
        .ctrl_c_o  (ctrl_c)
    );

    // ********************************************************
    // Signal enables
    // ********************************************************

    logic [pxb_pkg::NUM_SIGS-1:0] sig_en;
    logic [pxb_pkg::NUM_SIGS-1:0] sig_od;
    logic [2:0]                   cex_n;

    // Reserved codes 110 and 111 route no module outputs at all.
    assign cex_n = (ctrl_a.counter_module_io_count > 3'h5) ?
                   3'h0 : ctrl_a.counter_module_io_count;

    // Fixed-position groups come first in the priority order.
    assign sig_en[pxb_pkg::SIG_UART_A_TX] = ctrl_a.uart_a_route_en;
    assign sig_en[pxb_pkg::SIG_UART_A_RX] = ctrl_a.uart_a_route_en;
    assign sig_en[pxb_pkg::SIG_SMB_SDA]   = ctrl_a.smbus_route_en;
    assign sig_en[pxb_pkg::SIG_SMB_SCL]   = ctrl_a.smbus_route_en;
    assign sig_en[pxb_pkg::SIG_UART_B_TX] = ctrl_c.uart_b_route_en;
    assign sig_en[pxb_pkg::SIG_UART_B_RX] = ctrl_c.uart_b_route_en;

    // The four SPI lines share one enable.
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_spi
            assign sig_en[pxb_pkg::SIG_SPI_BASE+g] =
                ctrl_a.spi_route_en;
        end
        // Module output g is routed when cex_n exceeds g.
        for (g = 0; g < pxb_pkg::NUM_CEX; g++) begin : g_cex
            assign sig_en[pxb_pkg::SIG_CEX_BASE+g] =
                cex_n > 3'(g);
        end
    endgenerate

    // Single-signal enables.
    assign sig_en[pxb_pkg::SIG_ECI]   = ctrl_a.ext_count_in_route_en;
    assign sig_en[pxb_pkg::SIG_CMP_A] = ctrl_a.cmp_a_route_en;
    assign sig_en[pxb_pkg::SIG_CMP_B] = ctrl_b.cmp_b_route_en;
    assign sig_en[pxb_pkg::SIG_TMR_A] = ctrl_b.tmr_a_count_route_en;
    assign sig_en[pxb_pkg::SIG_IRQ_A] = ctrl_b.ext_irq_a_route_en;
    assign sig_en[pxb_pkg::SIG_TMR_B] = ctrl_b.tmr_b_count_route_en;
    assign sig_en[pxb_pkg::SIG_IRQ_B] = ctrl_b.ext_irq_b_route_en;
    assign sig_en[pxb_pkg::SIG_TMR_C] = ctrl_b.tmr_c_count_route_en;
    assign sig_en[pxb_pkg::SIG_TMR_C_TRG] =
        ctrl_b.tmr_c_trigger_route_en;
    assign sig_en[pxb_pkg::SIG_TMR_E] = ctrl_c.tmr_e_count_route_en;
    assign sig_en[pxb_pkg::SIG_TMR_E_TRG] =
        ctrl_c.tmr_e_trigger_route_en;
    assign sig_en[pxb_pkg::SIG_INV_CLK] =
        ctrl_b.inv_sysclk_route_en;
    assign sig_en[pxb_pkg::SIG_CONV] = ctrl_c.conv_start_route_en;

    // Lines that never drive high, whatever the port mode says: SMBus always, UART RX only in mode 0.
    always_comb begin
        sig_od = '0;
        sig_od[pxb_pkg::SIG_SMB_SDA]   = 1'b1;
        sig_od[pxb_pkg::SIG_SMB_SCL]   = 1'b1;
        sig_od[pxb_pkg::SIG_UART_A_RX] = uart_a_mode0_i;
        sig_od[pxb_pkg::SIG_UART_B_RX] = uart_b_mode0_i;
    end

    // ********************************************************
    // Skipped pins and allocation
    // ********************************************************

    logic [pxb_pkg::NUM_PINS-1:0] mem_pin;
    logic [pxb_pkg::NUM_PINS-1:0] analog_pin;
    logic [pxb_pkg::NUM_PINS-1:0] pin_skip;
    logic [pxb_pkg::NUM_PINS-1:0] pin_used;
    logic [pxb_pkg::NUM_SIGS-1:0] sig_placed;
    logic [4:0]                   pin_sig [pxb_pkg::NUM_PINS];
    logic [4:0]                   sig_pin [pxb_pkg::NUM_SIGS];
    logic [5:0]                   placed_n;

    // The memory interface claims the top of port 0; the address latch
    // strobe is only needed in multiplexed mode.
    always_comb begin
        mem_pin    = '0;
        analog_pin = '0;
        analog_pin[15:8] = analog_skip_i;
        mem_pin[7] = ctrl_c.memif_low_port_claim;
        mem_pin[6] = ctrl_c.memif_low_port_claim;
        mem_pin[5] = ctrl_c.memif_low_port_claim &&
                     !memif_nonmux_sel_i;
    end

    assign pin_skip = mem_pin | analog_pin;

    pxb_alloc u_alloc (
        .sig_en_i       (sig_en),
        .pin_skip_i     (pin_skip),
        .pin_used_o     (pin_used),
        .pin_sig_o      (pin_sig),
        .sig_placed_o   (sig_placed),
        .sig_pin_o      (sig_pin),
        .placed_count_o (placed_n)
    );

    // Overflow flags enabled signals that found no free pin.
    assign next_status = '{
        overflow:     |(sig_en & ~sig_placed),
        unused6:      1'b0,
        placed_count: placed_n
    };

    // ********************************************************
    // Pin input synchronisers
    // ********************************************************

    logic [pxb_pkg::NUM_PINS-1:0] pin_meta;
    logic [pxb_pkg::NUM_PINS-1:0] pin_sync;

    // Pins are asynchronous; only pin_sync is read by logic.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            pin_meta <= '1;
            pin_sync <= '1;
        end else begin
            pin_meta <= pin_i;
            pin_sync <= pin_meta;
        end
    end

    // ********************************************************
    // Pin drive
    // ********************************************************

    logic [pxb_pkg::NUM_PINS-1:0] next_val;
    logic [pxb_pkg::NUM_PINS-1:0] next_oe;
    logic [pxb_pkg::NUM_PINS-1:0] next_pu;

    generate
        for (g = 0; g < pxb_pkg::NUM_PINS; g++) begin : g_pin
            wire logic [4:0] s    = pin_sig[g];
            wire logic       want;
            wire logic       od;
            wire logic       val;
            // A claimed memory pin merges its strobe with the latch;
            // strobes idle high, so a low latch still pulls it down.
            if (g >= 5 && g <= 7) begin : g_mem
                wire logic strobe = memif_strobe_i[g-5];
                assign val = mem_pin[g] ? (latch_i[g] & strobe) :
                             pin_used[g] ? periph_out_i[s] :
                             latch_i[g];
            end else begin : g_plain
                assign val = pin_used[g] ? periph_out_i[s] : latch_i[g];
            end
            assign want = pin_used[g] && !mem_pin[g] ?
                          periph_oe_i[s] : 1'b1;
            assign od   = pin_used[g] && !mem_pin[g] && sig_od[s];
            // Open-drain drives only lows; a disabled crossbar drives
            // nothing, whatever peripherals and latches ask for.
            assign next_val[g] = val;
            assign next_oe[g]  = ctrl_c.crossbar_on && want &&
                                 (!val || (pushpull_i[g] && !od));
            assign next_pu[g]  = !ctrl_c.pullup_global_off &&
                                 !analog_pin[g];
        end
    endgenerate

    // Registered pin outputs keep the pads free of decode glitches.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            pin_o       <= '1;
            pin_oe_o    <= '0;
            pullup_en_o <= '1;
        end else begin
            pin_o       <= next_val;
            pin_oe_o    <= next_oe;
            pullup_en_o <= next_pu;
        end
    end

    // ********************************************************
    // Readback and peripheral inputs
    // ********************************************************

    logic [pxb_pkg::NUM_PINS-1:0] next_level;
    logic [pxb_pkg::NUM_SIGS-1:0] next_in;

    // Port reads see the pad, not the routing; analog pins read low.
    assign next_level = pin_sync & ~analog_pin;

    // An unrouted input idles high so that peripherals see no edges.
    generate
        for (g = 0; g < pxb_pkg::NUM_SIGS; g++) begin : g_in
            assign next_in[g] = (ctrl_c.crossbar_on && sig_placed[g]) ?
                                next_level[sig_pin[g]] : 1'b1;
        end
    endgenerate

    // Readback and inputs settle one edge after the pad sample; status one edge after the routing registers.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            pin_level_o <= '1;
            periph_in_o <= '1;
            status      <= '0;
        end else begin
            pin_level_o <= next_level;
            periph_in_o <= next_in;
            status      <= next_status;
        end
    end

endmodule
`default_nettype wire

// ==== core/pxb_pkg.sv ====
// Constants and types shared by the port crossbar files.
package pxb_pkg;

    // ********************************************************
    // Sizes
    // ********************************************************
    localparam int NUM_PINS  = 32;
    localparam int NUM_SIGS  = 28;
    localparam int ADR_W     = 10;
    localparam int NUM_CEX   = 5;

    // ********************************************************
    // Register indices; byte address is four times the index
    // ********************************************************
    localparam logic [7:0] IDX_CTRL_A = 8'he1;
    localparam logic [7:0] IDX_CTRL_B = 8'he2;
    localparam logic [7:0] IDX_CTRL_C = 8'he3;
    localparam logic [7:0] IDX_STATUS = 8'he4;
    localparam logic [7:0] RST_CTRL_A = 8'h00;
    localparam logic [7:0] RST_CTRL_B = 8'h00;
    localparam logic [7:0] RST_CTRL_C = 8'h00;
    localparam logic [7:0] CTRL_C_RSVD_MASK = 8'hdf;

    // ********************************************************
    // Signal slots in assignment priority order
    // ********************************************************
    localparam int SIG_UART_A_TX = 0;
    localparam int SIG_UART_A_RX = 1;
    localparam int SIG_SPI_BASE  = 2;
    localparam int SIG_SMB_SDA   = 6;
    localparam int SIG_SMB_SCL   = 7;
    localparam int SIG_UART_B_TX = 8;
    localparam int SIG_UART_B_RX = 9;
    localparam int SIG_CEX_BASE  = 10;
    localparam int SIG_ECI       = 15;
    localparam int SIG_CMP_A     = 16;
    localparam int SIG_CMP_B     = 17;
    localparam int SIG_TMR_A     = 18;
    localparam int SIG_IRQ_A     = 19;
    localparam int SIG_TMR_B     = 20;
    localparam int SIG_IRQ_B     = 21;
    localparam int SIG_TMR_C     = 22;
    localparam int SIG_TMR_C_TRG = 23;
    localparam int SIG_TMR_E     = 24;
    localparam int SIG_TMR_E_TRG = 25;
    localparam int SIG_INV_CLK   = 26;
    localparam int SIG_CONV      = 27;

    // ********************************************************
    // Register layouts, bit 7 first
    // ********************************************************
    typedef struct packed {
        logic       cmp_a_route_en;
        logic       ext_count_in_route_en;
        logic [2:0] counter_module_io_count;
        logic       uart_a_route_en;
        logic       spi_route_en;
        logic       smbus_route_en;
    } pxb_ctrl_a_s;

    typedef struct packed {
        logic inv_sysclk_route_en;
        logic tmr_c_trigger_route_en;
        logic tmr_c_count_route_en;
        logic ext_irq_b_route_en;
        logic tmr_b_count_route_en;
        logic ext_irq_a_route_en;
        logic tmr_a_count_route_en;
        logic cmp_b_route_en;
    } pxb_ctrl_b_s;

    typedef struct packed {
        logic pullup_global_off;
        logic crossbar_on;
        logic unused5;
        logic tmr_e_trigger_route_en;
        logic tmr_e_count_route_en;
        logic uart_b_route_en;
        logic memif_low_port_claim;
        logic conv_start_route_en;
    } pxb_ctrl_c_s;

    typedef struct packed {
        logic       overflow;
        logic       unused6;
        logic [5:0] placed_count;
    } pxb_status_s;

endpackage

// ==== core/pxb_wb_regs.sv ====
// Wishbone classic slave holding the crossbar routing registers.
`timescale 1ns/1ps
`default_nettype none
module pxb_wb_regs (
    // Clock and reset
    input  wire logic                     clk_sys_i,
    input  wire logic                     sys_rst_i,
    // Wishbone slave
    input  wire logic [pxb_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic [31:0]              wb_dat_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic                     wb_we_i,
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    output logic      [31:0]              wb_dat_o,
    output logic                          wb_ack_o,
    // Register contents and status
    input  wire pxb_pkg::pxb_status_s     status_i,
    output pxb_pkg::pxb_ctrl_a_s          ctrl_a_o,
    output pxb_pkg::pxb_ctrl_b_s          ctrl_b_o,
    output pxb_pkg::pxb_ctrl_c_s          ctrl_c_o
);

    // Decode: word index from the byte address, low lane written.
    wire logic [7:0] idx      = wb_adr_i[9:2];
    wire logic       req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic       wr       = req && wb_we_i && wb_sel_i[0];
    wire logic       hit_a    = idx == pxb_pkg::IDX_CTRL_A;
    wire logic       hit_b    = idx == pxb_pkg::IDX_CTRL_B;
    wire logic       hit_c    = idx == pxb_pkg::IDX_CTRL_C;
    wire logic       hit_s    = idx == pxb_pkg::IDX_STATUS;
    wire logic [7:0] rd_byte  = hit_a ? ctrl_a_o :
                                hit_b ? ctrl_b_o :
                                hit_c ? ctrl_c_o :
                                hit_s ? status_i : 8'h00;

    // One wait state; unmapped words ack with zero and drop writes.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= {24'h00_0000, rd_byte};
        end
    end

    // Routing register writes.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            ctrl_a_o <= pxb_pkg::RST_CTRL_A;
            ctrl_b_o <= pxb_pkg::RST_CTRL_B;
            ctrl_c_o <= pxb_pkg::RST_CTRL_C;
        end else if (wr && hit_a) begin
            ctrl_a_o <= wb_dat_i[7:0];
        end else if (wr && hit_b) begin
            ctrl_b_o <= wb_dat_i[7:0];
        end else if (wr && hit_c) begin
            ctrl_c_o <= wb_dat_i[7:0] & pxb_pkg::CTRL_C_RSVD_MASK;
        end
    end

endmodule
`default_nettype wire

// ==== testbench/pxb_crossbar_asserts.sv ====
// Checker of bus and pin relations at the crossbar ports.
`timescale 1ns/1ps
`default_nettype none
module pxb_crossbar_asserts (
    // Clock, reset and bus
    input wire logic        clk_sys_i,
    input wire logic        sys_rst_i,
    input wire logic [9:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic        wb_we_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Pin side
    input wire logic [27:0] periph_out_i,
    input wire logic [2:0]  memif_strobe_i,
    input wire logic [31:0] latch_i,
    input wire logic [31:0] pin_i,
    input wire logic [31:0] pin_o,
    input wire logic [31:0] pin_oe_o,
    input wire logic [31:0] pullup_en_o,
    input wire logic [31:0] pin_level_o
);
    logic [7:0] sh_a;
    logic [7:0] sh_c;
    logic [1:0] age;
    wire logic  wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & wb_ack_o;
    // Shadow writes; age hides the pad synchroniser after reset.
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            sh_a <= 8'h00;
            sh_c <= 8'h00;
            age  <= 2'h0;
        end else begin
            if (wr && wb_adr_i == 10'h384) sh_a <= wb_dat_i[7:0];
            if (wr && wb_adr_i == 10'h38c) sh_c <= wb_dat_i[7:0];
            if (age != 2'h3) age <= age + 2'h1;
        end
    end
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);
    sequence req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    ack_delay_a: assert property (req_s |=> wb_ack_o) else $error("no ack");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("long ack");
    rsvd_read_a: assert property (
        req_s ##0 (!wb_we_i && wb_adr_i == 10'h38c)
        |=> wb_dat_o == {24'h0, sh_c & 8'hdf}) else $error("bad read");
    xbar_off_a: assert property (
        !sh_c[6] [*2] |-> pin_oe_o == 32'h0) else $error("pin driven");
    pull_off_a: assert property (
        sh_c[7] ##1 sh_c[7] |-> pullup_en_o == 32'h0) else $error("pull-up");
    pull_on_a: assert property (
        !sh_c[7] ##1 !sh_c[7] |-> &{pullup_en_o[7:0], pullup_en_o[31:16]})
        else $error("no pull-up");
    sync_lat_a: assert property (
        age == 2'h3 |-> pin_level_o[7:0] == $past(pin_i[7:0], 3))
        else $error("bad level");
    uart_tx_a: assert property (
        (sh_c[6] && sh_a[2]) [*2] |-> pin_o[0] == $past(periph_out_i[0]))
        else $error("bad tx pin");
    memif_a: assert property (
        (sh_c[6] && sh_c[1]) [*2]
        |-> pin_o[7] == $past(latch_i[7] & memif_strobe_i[2]))
        else $error("bad strobe pin");
endmodule
bind pxb_crossbar pxb_crossbar_asserts u_chk (.clk_sys_i, .sys_rst_i,
    .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i,
    .wb_dat_o, .wb_ack_o, .periph_out_i, .memif_strobe_i, .latch_i,
    .pin_i, .pin_o, .pin_oe_o, .pullup_en_o, .pin_level_o);
`default_nettype wire

// ==== testbench/pxb_crossbar_tb.sv ====
// Self-checking bench for the port crossbar.
`timescale 1ns/1ps
`default_nettype none
module pxb_crossbar_tb;
    typedef struct packed {logic [9:0] a; logic [7:0] w; logic [7:0] e;}
        pxb_row_s;
    typedef struct packed {logic [7:0] b; logic [7:0] c; logic [5:0] n;
        logic [4:0] s;} pxb_sel_s;
    localparam pxb_row_s ROWS [4] = '{'{10'h384, 8'hff, 8'hff},
        '{10'h388, 8'ha5, 8'ha5}, '{10'h38c, 8'hff, 8'hdf},
        '{10'h3fc, 8'h55, 8'h00}};
    // One enable per row; its first signal must land on pin 0.
    localparam pxb_sel_s SELS [12] = '{'{8'h01, 8'h40, 6'h1, 5'h11},
        '{8'h02, 8'h40, 6'h1, 5'h12}, '{8'h04, 8'h40, 6'h1, 5'h13},
        '{8'h08, 8'h40, 6'h1, 5'h14}, '{8'h10, 8'h40, 6'h1, 5'h15},
        '{8'h20, 8'h40, 6'h1, 5'h16}, '{8'h40, 8'h40, 6'h1, 5'h17},
        '{8'h80, 8'h40, 6'h1, 5'h1a}, '{8'h00, 8'h41, 6'h1, 5'h1b},
        '{8'h00, 8'h44, 6'h2, 5'h08}, '{8'h00, 8'h48, 6'h1, 5'h18},
        '{8'h00, 8'h50, 6'h1, 5'h19}};
    logic             clk_sys_i = 1'b0;
    logic             sys_rst_i = 1'b1;
    logic [9:0]       wb_adr_i = 10'h000;
    logic [31:0]      wb_dat_i = 32'h0;
    logic [3:0]       wb_sel_i = 4'hf;
    logic             wb_we_i = 1'b0;
    logic             wb_cyc_i = 1'b0;
    logic             wb_stb_i = 1'b0;
    logic [27:0]      periph_out_i = 28'haaaaaaa;
    logic [27:0]      periph_oe_i = 28'hfffffff;
    logic             uart_a_mode0_i = 1'b0;
    logic             uart_b_mode0_i = 1'b0;
    logic             memif_nonmux_sel_i = 1'b0;
    logic [2:0]       memif_strobe_i = 3'h2;
    logic [31:0]      latch_i = 32'h0;
    logic [31:0]      pushpull_i = 32'hffffffff;
    logic [7:0]       analog_skip_i = 8'h00;
    logic [31:0]      ext_oe = 32'h0;
    logic [31:0]      rd;
    wire logic [31:0] pin_i, pin_o, pin_oe_o, pullup_en_o, pin_level_o;
    wire logic [31:0] wb_dat_o;
    wire logic [27:0] periph_in_o;
    wire logic        wb_ack_o;
    int               n_errors = 0;
    int               n_tests = 0;
    int               cycles = 0;
    pxb_crossbar dut (.clk_sys_i, .sys_rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i,
        .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .periph_out_i,
        .periph_oe_i, .periph_in_o, .uart_a_mode0_i, .uart_b_mode0_i,
        .memif_nonmux_sel_i, .memif_strobe_i, .latch_i, .pushpull_i,
        .analog_skip_i, .pin_i, .pin_o, .pin_oe_o, .pullup_en_o, .pin_level_o);
    pxb_pad_model u_pad (.clk_sys_i, .xb_val_i(pin_o), .xb_oe_i(pin_oe_o),
        .pu_en_i(pullup_en_o), .ext_oe_i(ext_oe), .pad_o(pin_i));
    initial forever #2.5 clk_sys_i = ~clk_sys_i;
    // A hung handshake ends the run here instead of stalling.
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            conclude();
        end
    end
    task automatic conclude();
        if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Waits n edges; checks then see what stood before the last one.
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    // Classic cycle held until ack, then one idle cycle.
    task automatic wb(input logic [9:0] a, input logic we, input logic [7:0] d);
        wb_adr_i <= a;
        wb_we_i  <= we;
        wb_dat_i <= {24'h0, d};
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do @(posedge clk_sys_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task automatic setr(input logic [7:0] ra, rb, rc);
        wb(10'h384, 1'b1, ra);
        wb(10'h388, 1'b1, rb);
        wb(10'h38c, 1'b1, rc);
        tick(2);
    endtask
    task automatic cnt(input logic [5:0] e);
        wb(10'h390, 1'b0, 8'h00);
        check(rd & 32'h3f, {26'h0, e});
    endtask
    initial begin
        tick(10);
        sys_rst_i <= 1'b0;
        tick(1);
        foreach (ROWS[i]) begin
            wb(ROWS[i].a, 1'b0, 8'h00);
            check(rd, 32'h0);
            wb(ROWS[i].a, 1'b1, ROWS[i].w);
            wb(ROWS[i].a, 1'b0, 8'h00);
            check(rd, {24'h0, ROWS[i].e});
        end
        foreach (SELS[i]) begin
            setr(8'h00, SELS[i].b, SELS[i].c);
            cnt(SELS[i].n);
            check(32'(pin_o[0]), 32'(periph_out_i[SELS[i].s]));
        end
        // Counter field: the two top codes route nothing.
        for (int c = 0; c < 8; c++) begin
            setr({2'h0, 3'(c), 3'h0}, 8'h00, 8'h40);
            cnt(c < 6 ? 6'(c) : 6'h0);
        end
        setr(8'h1f, 8'h00, 8'h40);
        cnt(6'hb);
        check(32'(pin_o[11:0]), {21'h0, periph_out_i[12:10],
            periph_out_i[7:0]});
        setr(8'h04, 8'h00, 8'h44);
        ext_oe <= 32'h2;
        tick(4);
        check(32'({periph_in_o[1], pin_level_o[1]}), 32'h0);
        ext_oe <= 32'h0;
        {uart_a_mode0_i, uart_b_mode0_i} <= 2'h3;
        periph_out_i <= 28'hfffffff;
        tick(2);
        check(32'(pin_oe_o[3:0]), 32'h5);
        setr(8'h01, 8'h00, 8'h40);
        check(32'(pin_oe_o[1:0]), 32'h0);
        periph_out_i <= 28'haaaaaaa;
        {uart_a_mode0_i, uart_b_mode0_i} <= 2'h0;
        latch_i <= 32'hffffffff;
        setr(8'h1f, 8'h00, 8'h42);
        check(32'(pin_o[8:5]), {28'h0, periph_out_i[5], 3'h2});
        memif_nonmux_sel_i <= 1'b1;
        tick(2);
        check(32'(pin_o[7:5]), {29'h1, periph_out_i[5]});
        setr(8'h1f, 8'h00, 8'h40);
        check(32'(pin_o[7:5]), 32'(periph_out_i[7:5]));
        analog_skip_i <= 8'h0f;
        setr(8'h00, 8'h00, 8'hc0);
        check(pullup_en_o, 32'h0);
        setr(8'h00, 8'h00, 8'h40);
        check(pullup_en_o, 32'hfffff0ff);
        setr(8'hff, 8'hff, 8'h00);
        check(pin_oe_o, 32'h0);
        check({4'h0, periph_in_o}, 32'h0fffffff);
        setr(8'h04, 8'h00, 8'h40);
        sys_rst_i <= 1'b1;
        tick(2);
        sys_rst_i <= 1'b0;
        tick(1);
        check(pin_oe_o | ~pullup_en_o, 32'h0);
        wb(10'h38c, 1'b0, 8'h00);
        check(rd, 32'h0);
        conclude();
    end
endmodule
`default_nettype wire

// ==== testbench/pxb_pad_model.sv ====
// Pad model: resolves each pin from both drivers and the pull-up.
`timescale 1ns/1ps
`default_nettype none
module pxb_pad_model (
    // Drivers
    input  wire logic        clk_sys_i,
    input  wire logic [31:0] xb_val_i,
    input  wire logic [31:0] xb_oe_i,
    input  wire logic [31:0] pu_en_i,
    input  wire logic [31:0] ext_oe_i,
    // Pad level
    output logic      [31:0] pad_o
);
    logic      tog = 1'b0;
    wire logic [31:0] drv = xb_oe_i | ext_oe_i;
    // A floating pad has no true level, so it wanders each cycle.
    always @(posedge clk_sys_i) tog <= ~tog;
    // The far side only pulls low, so the drivers form a wired-AND.
    assign pad_o = drv & (~xb_oe_i | xb_val_i) & ~ext_oe_i
                 | ~drv & (pu_en_i | {32{tog}});
endmodule
`default_nettype wire
